// ### rtl/erf_monitor.sv
// E3 remote failure monitor with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
// Operation
// RL1: Monitor only while parity checking disabled
// RL2: Parity enabled: alarm bit means block error
// RL3: Declare after 3 or 5 ones
// RL4: Declare sets read-only status bit 0
// RL5: Status holds until defect cleared
// RL6: Declare sets change interrupt, interrupt low
// RL7: Clear after selectable zero frames
// RL8: Transmit alarm bit while local defects, configured
// RL9: Clear needs 3 or 5 zeros
// RL10: Clear resets status, sets change interrupt
// RL11: Read clears interrupt status; output releases
module erf_monitor #(
	parameter int CNT_W = 4
)(
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Received frames
	input  wire logic        frame_valid_in,
	input  wire logic        alarm_bit_in,
	// Local receive defects
	input  wire logic        los_in,
	input  wire logic        oof_in,
	input  wire logic        lof_in,
	input  wire logic        ais_in,
	// Results
	output logic             far_end_block_error_out,
	output logic             tx_remote_failure_indication_out,
	output logic             int_n_out
);

	// Elaboration checks on the parameters
	if (CNT_W < 3)
	begin : g_cnt_min
		$error("CNT_W too small for frame count");
	end

	if ((2 ** CNT_W) <= int'(erf_pkg::FRAMES_LONG))
	begin : g_cnt_fit
		$error("CNT_W cannot hold the long frame count");
	end

	if ((erf_pkg::ADDR_W - 2) != 16)
	begin : g_idx_fit
		$error("ADDR_W must give a sixteen bit register index");
	end

	// Register state
	logic [7:0]       cfg_one_r;
	logic             loss_sel_r;
	logic             defect_r;
	logic             change_r;
	logic [7:0]       int_en_r;
	logic [7:0]       tx_ctrl_r;
	logic [CNT_W-1:0] run_r;
	logic             feb_r;
	logic [31:0]      rdata_r;
	// Data phase capture
	logic             wr_pend_r;
	logic [15:0]      wr_idx_r;

	function automatic logic [CNT_W-1:0] frames_needed(input logic long_sel);
		frames_needed = long_sel ? CNT_W'(erf_pkg::FRAMES_LONG)
		                         : CNT_W'(erf_pkg::FRAMES_SHORT);
	endfunction : frames_needed

	function automatic logic [15:0] idx_of(input logic [31:0] addr);
		idx_of = addr[erf_pkg::ADDR_W-1:2];
	endfunction : idx_of

	logic             addr_ok;
	logic [15:0]      a_idx;
	logic             rd_int;
	logic             parity_on;
	logic             persist;
	logic             opposite;
	logic             toggle;
	logic [CNT_W-1:0] need;

	assign addr_ok   = hsel_in & hready_in & htrans_in[erf_pkg::HTRANS_ACTIVE_BIT];
	assign a_idx     = idx_of(haddr_in);
	assign rd_int    = addr_ok & ~hwrite_in & (a_idx == erf_pkg::IDX_INT_TWO);
	assign parity_on = cfg_one_r[erf_pkg::CFG1_PARITY_BIT];
	assign persist   = cfg_one_r[erf_pkg::CFG1_PERSIST_BIT];
	assign need      = frames_needed(persist);
	// Frame whose alarm bit disagrees with the present defect state
	assign opposite  = frame_valid_in & ~parity_on & (alarm_bit_in != defect_r); // RL1
	assign toggle    = opposite & (run_r == need - CNT_W'(1)); // RL3 RL7 RL9

	// Bus handshake
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// Write capture, pending flag
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			wr_pend_r <= 1'b0;
		else if (hready_in)
			wr_pend_r <= addr_ok & hwrite_in;
	end

	// Write capture, register index
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			wr_idx_r <= 16'h0000;
		else if (hready_in)
			wr_idx_r <= a_idx;
	end

	// Write strobes, one per writable register
	logic             wr_cfg_one;
	logic             wr_cfg_two;
	logic             wr_int_en;
	logic             wr_tx_ctrl;

	function automatic logic wr_hit(
		input logic        pend,
		input logic [15:0] idx,
		input logic [15:0] reg_idx
	);
		wr_hit = pend & (idx == reg_idx);
	endfunction : wr_hit

	assign wr_cfg_one = wr_hit(wr_pend_r, wr_idx_r, erf_pkg::IDX_CFG_ONE);
	assign wr_cfg_two = wr_hit(wr_pend_r, wr_idx_r, erf_pkg::IDX_CFG_TWO);
	assign wr_int_en  = wr_hit(wr_pend_r, wr_idx_r, erf_pkg::IDX_INT_EN);
	assign wr_tx_ctrl = wr_hit(wr_pend_r, wr_idx_r, erf_pkg::IDX_TX_CTRL);

	// Configuration one: parity enable and persistence select
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			cfg_one_r <= erf_pkg::CFG1_RESET;
		else if (wr_cfg_one)
		begin
			cfg_one_r[erf_pkg::CFG1_PARITY_BIT]  <= hwdata_in[erf_pkg::CFG1_PARITY_BIT]; // RL1
			cfg_one_r[erf_pkg::CFG1_PERSIST_BIT] <= hwdata_in[erf_pkg::CFG1_PERSIST_BIT]; // RL3
		end
	end

	// Configuration two: only the loss select bit is writable
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			loss_sel_r <= 1'b0;
		else if (wr_cfg_two)
			loss_sel_r <= hwdata_in[erf_pkg::CFG2_LOSS_SEL_BIT];
	end

	// Interrupt enable
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			int_en_r <= erf_pkg::INT_EN_RESET;
		else if (wr_int_en)
			int_en_r[erf_pkg::INT2_CHANGE_BIT] <= hwdata_in[erf_pkg::INT2_CHANGE_BIT];
	end

	// Transmit control
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			tx_ctrl_r <= erf_pkg::TX_CTRL_RESET;
		else if (wr_tx_ctrl)
			tx_ctrl_r[erf_pkg::TX_AUTO_BIT] <= hwdata_in[erf_pkg::TX_AUTO_BIT];
	end

	// Consecutive frame counter
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			run_r <= '0;
		else if (parity_on)
			run_r <= '0; // RL1
		else if (frame_valid_in)
		begin
			if (opposite && !toggle)
				run_r <= run_r + CNT_W'(1); // RL3 RL9
			else
				run_r <= '0;
		end
	end

	// Defect state
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			defect_r <= 1'b0;
		else if (toggle)
			defect_r <= ~defect_r; // RL4 RL5 RL7 RL10
	end

	// Change interrupt status, set wins over read clear
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			change_r <= 1'b0;
		else if (toggle)
			change_r <= 1'b1; // RL6 RL10
		else if (rd_int)
			change_r <= 1'b0; // RL11
	end

	// Far-end block error pulse
	logic             block_error_frame;

	assign block_error_frame = frame_valid_in & parity_on & alarm_bit_in; // RL2

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			feb_r <= 1'b0;
		else
			feb_r <= block_error_frame; // RL2
	end
	assign far_end_block_error_out = feb_r;

	// Interrupt output, low while an enabled change is pending
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			int_n_out <= 1'b1;
		else
			int_n_out <= ~(change_r & int_en_r[erf_pkg::INT2_CHANGE_BIT]); // RL6 RL11
	end

	// Transmit alarm request while any local receive defect stands
	logic             local_defect;

	assign local_defect = los_in | oof_in | lof_in | ais_in;

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			tx_remote_failure_indication_out <= 1'b0;
		else
			tx_remote_failure_indication_out <= tx_ctrl_r[erf_pkg::TX_AUTO_BIT]
				& local_defect; // RL8
	end

	// Register views as software sees them
	logic [7:0]       cfg_two_view;
	logic [7:0]       int_two_view;
	logic [7:0]       rd_byte;

	always_comb
	begin
		cfg_two_view                             = 8'h00;
		cfg_two_view[erf_pkg::CFG2_REMOTE_BIT]   = defect_r; // RL4 RL5
		cfg_two_view[erf_pkg::CFG2_AIS_BIT]      = ais_in;
		cfg_two_view[erf_pkg::CFG2_LOS_BIT]      = los_in;
		cfg_two_view[erf_pkg::CFG2_OOF_BIT]      = oof_in;
		cfg_two_view[erf_pkg::CFG2_LOF_BIT]      = lof_in;
		cfg_two_view[erf_pkg::CFG2_LOSS_SEL_BIT] = loss_sel_r;
	end

	always_comb
	begin
		int_two_view                           = 8'h00;
		int_two_view[erf_pkg::INT2_CHANGE_BIT] = change_r;
	end

	function automatic logic [7:0] read_byte(
		input logic [15:0] idx,
		input logic [7:0]  cfg_one,
		input logic [7:0]  cfg_two,
		input logic [7:0]  int_two,
		input logic [7:0]  int_en,
		input logic [7:0]  tx_ctrl
	);
		unique case (idx)
			erf_pkg::IDX_CFG_ONE:
				read_byte = cfg_one;
			erf_pkg::IDX_CFG_TWO:
				read_byte = cfg_two;
			erf_pkg::IDX_INT_TWO:
				read_byte = int_two;
			erf_pkg::IDX_INT_EN:
				read_byte = int_en;
			erf_pkg::IDX_TX_CTRL:
				read_byte = tx_ctrl;
			default:
				read_byte = 8'h00;
		endcase
	endfunction : read_byte

	assign rd_byte = read_byte(a_idx, cfg_one_r, cfg_two_view, int_two_view,
		int_en_r, tx_ctrl_r);

	// Read data, captured in the address phase and held through the data phase
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			rdata_r <= 32'h0000_0000;
		else if (addr_ok && !hwrite_in)
			rdata_r <= {24'h00_0000, rd_byte};
	end

	assign hrdata_out = rdata_r;

endmodule : erf_monitor
`default_nettype wire

// ### rtl/erf_pkg.sv
// Constants for the E3 remote failure monitor
package erf_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [15:0] IDX_CFG_ONE   = 16'h1110;
	localparam logic [15:0] IDX_CFG_TWO   = 16'h1111;
	localparam logic [15:0] IDX_INT_TWO   = 16'h1115;
	localparam logic [15:0] IDX_INT_EN    = 16'h1116;
	localparam logic [15:0] IDX_TX_CTRL   = 16'h1117;
	localparam int          ADDR_W        = 18;
	// Field positions
	localparam int          CFG1_PARITY_BIT   = 0;
	localparam int          CFG1_PERSIST_BIT  = 4;
	localparam int          CFG2_REMOTE_BIT   = 0;
	localparam int          CFG2_AIS_BIT      = 3;
	localparam int          CFG2_LOS_BIT      = 4;
	localparam int          CFG2_OOF_BIT      = 5;
	localparam int          CFG2_LOF_BIT      = 6;
	localparam int          CFG2_LOSS_SEL_BIT = 7;
	localparam int          INT2_CHANGE_BIT   = 3;
	localparam int          TX_AUTO_BIT       = 0;
	// Reset values
	localparam logic [7:0]  CFG1_RESET    = 8'h00;
	localparam logic [7:0]  INT_EN_RESET  = 8'h08;
	localparam logic [7:0]  TX_CTRL_RESET = 8'h00;
	// Consecutive frame counts
	localparam logic [3:0]  FRAMES_SHORT  = 4'h3;
	localparam logic [3:0]  FRAMES_LONG   = 4'h5;
	// AHB transfer type bit that marks an active transfer
	localparam int          HTRANS_ACTIVE_BIT = 1;
endpackage : erf_pkg

// ### tb/erf_far_end.sv
// Remote E3 terminal sending frame pulses that carry the alarm bit
`timescale 1ns/10ps
`default_nettype none
module erf_far_end (
	input  wire logic       clk_in, en_in, a_in,
	input  wire logic [3:0] gap_in,
	output logic            fv_out = 1'b0, ab_out = 1'b0
);
	logic [3:0] cnt_r = 4'h0;
	always_ff @(posedge clk_in)
	begin
		fv_out <= en_in && cnt_r == 4'h0;
		ab_out <= en_in && cnt_r == 4'h0 ? a_in : ~ab_out;
		cnt_r  <= !en_in || cnt_r == 4'h0 ? gap_in : cnt_r - 4'h1;
	end
endmodule : erf_far_end
`default_nettype wire

// ### tb/erf_sva.sv
// Port checker for the E3 remote failure monitor
`timescale 1ns/10ps
`default_nettype none
module erf_sva (
	input wire logic        ref_clk_in, rst_n_in, hsel_in, hwrite_in, hready_in,
	input wire logic [1:0]  htrans_in,
	input wire logic [31:0] hrdata_out,
	input wire logic        hreadyout_out, hresp_out, frame_valid_in, alarm_bit_in,
	input wire logic        los_in, oof_in, lof_in, ais_in, far_end_block_error_out,
	input wire logic        tx_remote_failure_indication_out, int_n_out
);
	wire rd = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	bus_ok_a: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer not ready or not okay");
	upper_zero_a: assert property (hrdata_out[31:8] == 24'h0)
		else $error("upper read bits set");
	read_hold_a: assert property (!rd |=> $stable(hrdata_out))
		else $error("read data moved");
	feb_cause_a: assert property (far_end_block_error_out |-> $past(frame_valid_in))
		else $error("block error without frame");
	feb_zero_a: assert property (frame_valid_in && !alarm_bit_in |=> !far_end_block_error_out)
		else $error("block error on clear frame");
	int_fall_a: assert property ($fell(int_n_out) |-> $past(frame_valid_in, 2))
		else $error("interrupt without frame");
	int_rise_a: assert property ($rose(int_n_out) |-> $past(rd, 2))
		else $error("interrupt released without read");
	tx_cause_a: assert property (tx_remote_failure_indication_out |->
		$past(los_in || oof_in || lof_in || ais_in)) else $error("tx alarm without defect");
	cover property ($fell(int_n_out));
	cover property (far_end_block_error_out);
	cover property (tx_remote_failure_indication_out);
endmodule : erf_sva
bind erf_monitor erf_sva u_sva (.*);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the E3 remote failure monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam logic [15:0] R1 = erf_pkg::IDX_CFG_ONE, R2 = erf_pkg::IDX_CFG_TWO;
	localparam logic [15:0] RI = erf_pkg::IDX_INT_TWO;
	logic        clk = 0, rst_n = 0, hsel = 0, hw = 0, en = 0, a = 0, fv, ab, int_n, tx, rdy, feb;
	logic [1:0]  ht = 0;
	logic [31:0] ha = 0, wd = 0, rd, q;
	logic [3:0]  dft = 0, gap = 1;
	int          fail_count = 0, n_compared = 0, cyc = 0, feb_n = 0;
	erf_monitor u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(ha),
		.htrans_in(ht), .hwrite_in(hw), .hsize_in(3'h2), .hwdata_in(wd), .hready_in(rdy),
		.hrdata_out(rd), .hreadyout_out(rdy), .hresp_out(), .frame_valid_in(fv),
		.alarm_bit_in(ab), .los_in(dft[0]), .oof_in(dft[1]), .lof_in(dft[2]), .ais_in(dft[3]),
		.far_end_block_error_out(feb), .tx_remote_failure_indication_out(tx), .int_n_out(int_n));
	erf_far_end u_far (.clk_in(clk), .en_in(en), .a_in(a), .gap_in(gap), .fv_out(fv), .ab_out(ab));
	task results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [15:0] i, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1; ht <= 2'h2; hw <= w; ha <= {14'h0, i, 2'h0};
		do @(posedge clk); while (rdy !== 1'b1);
		hsel <= 0; ht <= 2'h0; wd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = rd;
	endtask : bus
	task frames(input int n, input logic v);
		@(posedge clk);
		a <= v; en <= 1;
		repeat (n)
		begin
			do @(posedge clk); while (fv !== 1'b1);
			gap <= 4'h1 + 4'($urandom % 8);
		end
		en <= 0;
	endtask : frames
	function automatic int need(input logic s);
		return int'(s ? erf_pkg::FRAMES_LONG : erf_pkg::FRAMES_SHORT);
	endfunction : need
	initial forever #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (feb === 1'b1)
			feb_n++;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end
	initial
	begin
		void'($urandom(32'h6d2e));
		repeat (6) @(posedge clk);
		rst_n <= 1;
		for (int s = 0; s < 3; s++)
		begin
			bus(1, erf_pkg::IDX_INT_EN, s == 2 ? 32'h0 : 32'h8);
			bus(1, R1, s[0] ? 32'h10 : 32'h0);
			frames(need(s[0]) - 1, 1);
			frames(1, 0);
			frames(need(s[0]) - 1, 1);
			bus(0, R2, 0);
			chk("defect early", q[0], 0);
			frames(1, 1);
			repeat (2) @(posedge clk);
			chk("int set", int_n, s == 2);
			bus(0, R2, 0);
			chk("defect", q[0], 1);
			bus(0, RI, 0);
			chk("change", q, 32'h8);
			bus(0, RI, 0);
			chk("change read", q, 0);
			chk("int off", int_n, 1);
			$display("declare test %0d done", s);
			if (s == 2)
				break;
			frames(need(s[0]) - 1, 0);
			bus(0, R2, 0);
			chk("hold", q[0], 1);
			frames(1, 0);
			repeat (2) @(posedge clk);
			chk("int clear", int_n, 0);
			bus(0, R2, 0);
			chk("cleared", q[0], 0);
			bus(0, RI, 0);
			chk("change clear", q, 32'h8);
		end
		bus(1, R1, 32'h1);
		bus(1, R2, 32'h0);
		frames(5, 0);
		frames(5, 1);
		bus(0, R2, 0);
		chk("frozen", q[0], 1);
		bus(0, RI, 0);
		chk("no change", q, 0);
		chk("block errors", feb_n, 5);
		bus(1, 16'h1120, 32'hff);
		bus(0, 16'h1120, 0);
		chk("unmapped", q, 0);
		bus(1, erf_pkg::IDX_TX_CTRL, 32'h1);
		repeat (8)
		begin
			@(posedge clk);
			dft <= 4'($urandom);
			repeat (2) @(posedge clk);
			chk("tx alarm", tx, |dft);
		end
		$display("parity and transmit test done");
		results();
	end
endmodule : testbench
`default_nettype wire
